//--- blcl_pkg.sv
// Shared constants and types for the black level correction loop
package blcl_pkg;

  // Register offsets
  localparam logic [7:0] BLCL_ADDR_CTRL = 8'h08;
  localparam logic [7:0] BLCL_ADDR_POS  = 8'h09;

  // Reset values
  localparam logic [7:0] BLCL_CTRL_RST  = 8'h00;
  localparam logic [7:0] BLCL_POS_RST   = 8'h00;

  // Field positions in the clamp control register
  localparam int BLCL_REFSEL_LSB  = 0;
  localparam int BLCL_INTEG_LSB   = 2;
  localparam int BLCL_PIXAVG_LSB  = 4;
  localparam int BLCL_LINEAVG_LSB = 6;

  // Reference pulse selection codes
  localparam logic [1:0] BLCL_REF_SHIFT = 2'h1;
  localparam logic [1:0] BLCL_REF_CLAMP = 2'h2;

  // Line averaging codes; the last one runs on every line that finds the sequencer idle
  localparam logic [1:0] BLCL_LINES_15  = 2'h0;
  localparam logic [1:0] BLCL_LINES_31  = 2'h1;
  localparam logic [1:0] BLCL_LINES_63  = 2'h2;
  localparam logic [1:0] BLCL_LINES_INF = 2'h3;

  // Line counts, pixel and error shifts
  localparam logic [5:0] BLCL_LIM_15     = 6'h0F;
  localparam logic [5:0] BLCL_LIM_31     = 6'h1F;
  localparam logic [5:0] BLCL_LIM_63     = 6'h3F;
  localparam int         BLCL_PIX_SHIFT0 = 2;
  localparam int         BLCL_ERR_SHIFT0 = 3;

  // Target compare level taken from the upper ADC bits
  localparam int BLCL_ADC_W  = 16;
  localparam int BLCL_CMP_W  = 12;
  localparam int BLCL_TGT_W  = 10;
  localparam int BLCL_DROP_W = BLCL_ADC_W - BLCL_CMP_W;

  typedef enum logic [1:0] {
    BLCL_IDLE   = 2'b00,
    BLCL_DELAY  = 2'b01,
    BLCL_WINDOW = 2'b10,
    BLCL_UPDATE = 2'b11
  } blcl_state_t;

  function automatic logic [5:0] blcl_line_limit(input logic [1:0] sel);
    case (sel)
      BLCL_LINES_15: blcl_line_limit = BLCL_LIM_15;
      BLCL_LINES_31: blcl_line_limit = BLCL_LIM_31;
      default:       blcl_line_limit = BLCL_LIM_63;
    endcase
  endfunction : blcl_line_limit

  function automatic logic [5:0] blcl_pix_total(input logic [1:0] sel);
    blcl_pix_total = 6'(6'h01 << (BLCL_PIX_SHIFT0 + int'(sel)));
  endfunction : blcl_pix_total

endpackage : blcl_pkg

//--- blcl_pix_avg.sv
// Pixel accumulator and power-of-two averager
`timescale 1ns/100ps
module blcl_pix_avg
  import blcl_pkg::*;
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  clear_i,
  input  wire logic                  acc_en_i,
  input  wire logic [BLCL_ADC_W-1:0] adc_code_i,
  input  wire logic [1:0]            pix_sel_i,
  output logic      [BLCL_CMP_W-1:0] avg_o
);

  // Room for 32 compare-level samples
  localparam int SUM_W = BLCL_CMP_W + 5;

  logic [SUM_W-1:0] sum;
  logic [SUM_W-1:0] next_sum;
  logic [SUM_W-1:0] shifted;
  wire  [BLCL_CMP_W-1:0] sample = adc_code_i[BLCL_ADC_W-1:BLCL_DROP_W];

  assign next_sum = sum + SUM_W'(sample);
  assign shifted  = sum >> (BLCL_PIX_SHIFT0 + int'(pix_sel_i));
  assign avg_o    = shifted[BLCL_CMP_W-1:0];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sum <= '0;
    end else if (clear_i) begin
      sum <= '0;
    end else if (acc_en_i) begin
      sum <= next_sum;
    end
  end

endmodule : blcl_pix_avg

//--- blcl_offset_integ.sv
// Scaled error integration with saturation to the DAC range
`timescale 1ns/100ps
module blcl_offset_integ
  import blcl_pkg::*;
#(
  parameter int OFFSET_W = 10
)
(
  input  wire logic signed [OFFSET_W-1:0]   offset_i,
  input  wire logic        [BLCL_CMP_W-1:0] avg_i,
  input  wire logic        [BLCL_TGT_W-1:0] target_i,
  input  wire logic        [1:0]            integ_sel_i,
  output logic signed      [OFFSET_W-1:0]   next_offset_o
);

  localparam int ERR_W = BLCL_CMP_W + 1;
  localparam int EXT_W = OFFSET_W + ERR_W + 1;

  localparam logic signed [EXT_W-1:0] OFS_MAX =
    EXT_W'((64'sd1 <<< (OFFSET_W - 1)) - 64'sd1);
  localparam logic signed [EXT_W-1:0] OFS_MIN =
    EXT_W'(-(64'sd1 <<< (OFFSET_W - 1)));

  logic signed [ERR_W-1:0] err;
  logic signed [ERR_W-1:0] delta;
  logic signed [EXT_W-1:0] raw;

  // Target minus average gives a positive error when black sits too low
  assign err = $signed({3'h0, target_i}) - $signed({1'b0, avg_i});
  // Arithmetic shift keeps the sign of small negative errors
  assign delta = err >>> (BLCL_ERR_SHIFT0 + int'(integ_sel_i));
  assign raw = EXT_W'(offset_i) + EXT_W'(delta);

  // No limit other than the DAC itself, and no wrap past it
  assign next_offset_o = (raw > OFS_MAX) ? OFS_MAX[OFFSET_W-1:0] :
                         (raw < OFS_MIN) ? OFS_MIN[OFFSET_W-1:0] :
                         raw[OFFSET_W-1:0];

endmodule : blcl_offset_integ

//--- blcl_loop.sv
// Automatic black level correction loop for one channel
//
// Overview of operation
// - Disabled loop leaves manual offset untouched
// - Enabled loop rewrites offset on active lines
// - Window timed from shift or clamp fall
// - Window starts n pixels after reference edge
// - Window samples and averages black pixels
// - Averages 4, 8, 16 or 32 pixels
// - Ten-bit target compares against top ADC bits
// - Error is target minus pixel average
// - Error scaled by 1/8 to 1/64
// - Correction range limited only by DAC
// - Runs 15, 31, 63 lines or forever
// - Finite setting stops after its line count
// - Infinite setting updates every line that starts from idle while enabled
`timescale 1ns/100ps
module blcl_loop
  import blcl_pkg::*;
#(
  parameter int OFFSET_W = 10
)
(
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_n_i,
  // Register port
  input  wire logic                         reg_wr_i,
  input  wire logic [7:0]                   reg_addr_i,
  input  wire logic [7:0]                   reg_wr_data_i,
  output logic      [7:0]                   reg_rd_data_o,
  // Per-channel settings kept elsewhere in the chip
  input  wire logic                         loop_enable_i,
  input  wire logic [BLCL_TGT_W-1:0]        target_black_i,
  input  wire logic                         offset_wr_i,
  input  wire logic signed [OFFSET_W-1:0]   offset_wr_data_i,
  // Timing and data
  input  wire logic                         start_of_scan_i,
  input  wire logic                         sensor_shift_pulse_i,
  input  wire logic                         input_clamp_pulse_i,
  input  wire logic [BLCL_ADC_W-1:0]        adc_code_i,
  // Results
  output logic signed [OFFSET_W-1:0]        offset_dac_o,
  output logic                              black_calib_window_o,
  output logic                              loop_running_o,
  output logic [5:0]                        line_count_o
);

  //////////////////////////////////////////////////////////////////////////
  // Registers

  // Control fields, low to high: reference select, error divisor, pixels
  // per line, lines per scan. Reference codes 00 and 11 are stored but
  // open no window, so a freshly reset part stays quiet until software
  // picks a pulse.
  logic [7:0] black_clamp_control;
  logic [7:0] auto_clamp_position;

  wire wr_ctrl = reg_wr_i && (reg_addr_i == BLCL_ADDR_CTRL);
  wire wr_pos  = reg_wr_i && (reg_addr_i == BLCL_ADDR_POS);

  wire [1:0] ref_sel   = black_clamp_control[BLCL_REFSEL_LSB +: 2];
  wire [1:0] integ_sel = black_clamp_control[BLCL_INTEG_LSB +: 2];
  wire [1:0] pix_sel   = black_clamp_control[BLCL_PIXAVG_LSB +: 2];
  wire [1:0] line_sel  = black_clamp_control[BLCL_LINEAVG_LSB +: 2];

  logic [7:0] next_rd_data;
  assign next_rd_data = (reg_addr_i == BLCL_ADDR_CTRL) ? black_clamp_control :
                        (reg_addr_i == BLCL_ADDR_POS)  ? auto_clamp_position :
                        8'h00;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      black_clamp_control <= BLCL_CTRL_RST;
    end else if (wr_ctrl) begin
      black_clamp_control <= reg_wr_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auto_clamp_position <= BLCL_POS_RST;
    end else if (wr_pos) begin
      auto_clamp_position <= reg_wr_data_i;
    end
  end

  // Read data trails the address by one cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rd_data_o <= 8'h00;
    end else begin
      reg_rd_data_o <= next_rd_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reference edge

  // Delayed copies reset low, the idle level of both pulses, so the
  // release of reset never shows a false falling edge
  logic shift_d;
  logic clamp_d;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_d <= 1'b0;
      clamp_d <= 1'b0;
    end else begin
      shift_d <= sensor_shift_pulse_i;
      clamp_d <= input_clamp_pulse_i;
    end
  end

  wire shift_fall = shift_d && !sensor_shift_pulse_i;
  wire clamp_fall = clamp_d && !input_clamp_pulse_i;
  // Codes 00 and 11 select no reference, so no window ever opens
  wire ref_fall = ((ref_sel == BLCL_REF_SHIFT) && shift_fall) ||
                  ((ref_sel == BLCL_REF_CLAMP) && clamp_fall);

  //////////////////////////////////////////////////////////////////////////
  // Line counter

  logic [5:0] line_cnt;
  logic [5:0] next_line_cnt;

  // A finite setting of L lines runs the lines whose count, before the
  // increment, is 0 to L-1; later lines fail the compare and do nothing
  wire infinite  = (line_sel == BLCL_LINES_INF);
  wire lines_ok  = infinite ||
                   (line_cnt < blcl_line_limit(line_sel));
  // Saturates so a long scan never wraps back into the run range
  wire cnt_full  = (line_cnt == BLCL_LIM_63);

  assign next_line_cnt = start_of_scan_i ? 6'h00 :
                         (ref_fall && !cnt_full) ? line_cnt + 6'h01 :
                         line_cnt;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_cnt <= 6'h00;
    end else begin
      line_cnt <= next_line_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Window sequencer

  // One line with position n and N pixels, E being the edge that takes
  // the reference fall:
  //   E          idle to delay, delay count loaded with n
  //   E+1..E+n   delay count steps down to zero
  //   E+n+1      delay to window, pixel count loaded with N-1
  //   E+n+2..    one ADC code summed per edge, N in all
  //   E+n+N+1    window to update, average and error settle
  //   E+n+N+2    offset register takes the new value, back to idle
  // A reference fall that arrives while a line runs is counted but
  // starts nothing; the next line waits for the following fall, so a
  // long position plus a long window can swallow every other line.

  blcl_state_t state;
  blcl_state_t next_state;
  logic [7:0]  delay_cnt;
  logic [7:0]  next_delay_cnt;
  logic [5:0]  pix_cnt;
  logic [5:0]  next_pix_cnt;

  wire start_line = ref_fall && loop_enable_i && lines_ok;
  wire pix_last   = (pix_cnt == 6'h00);
  wire delay_done = (delay_cnt == 8'h00);

  always_comb begin
    next_state     = state;
    next_delay_cnt = delay_cnt;
    next_pix_cnt   = pix_cnt;
    case (state)
      BLCL_IDLE: begin
        if (start_line) begin
          next_state     = BLCL_DELAY;
          next_delay_cnt = auto_clamp_position;
        end
      end
      BLCL_DELAY: begin
        if (delay_done) begin
          next_state   = BLCL_WINDOW;
          next_pix_cnt = blcl_pix_total(pix_sel) - 6'h01;
        end else begin
          next_delay_cnt = delay_cnt - 8'h01;
        end
      end
      BLCL_WINDOW: begin
        if (pix_last) begin
          next_state = BLCL_UPDATE;
        end else begin
          next_pix_cnt = pix_cnt - 6'h01;
        end
      end
      BLCL_UPDATE: begin
        next_state = BLCL_IDLE;
      end
      default: begin
        next_state = BLCL_IDLE;
      end
    endcase
    // Disabling mid-line drops the measurement without touching the DAC
    if (!loop_enable_i) begin
      next_state = BLCL_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= BLCL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      delay_cnt <= 8'h00;
      pix_cnt   <= 6'h00;
    end else begin
      delay_cnt <= next_delay_cnt;
      pix_cnt   <= next_pix_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Averaging and integration

  logic [BLCL_CMP_W-1:0]       avg;
  logic signed [OFFSET_W-1:0]  next_offset;
  logic signed [OFFSET_W-1:0]  offset;

  wire in_window = (state == BLCL_WINDOW);
  // The sum is cleared in every idle cycle, so an aborted line leaves
  // nothing behind for the next window to add to

  blcl_pix_avg u_pix_avg (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .clear_i    (state == BLCL_IDLE),
    .acc_en_i   (in_window),
    .adc_code_i (adc_code_i),
    .pix_sel_i  (pix_sel),
    .avg_o      (avg)
  );

  blcl_offset_integ #(
    .OFFSET_W (OFFSET_W)
  ) u_offset_integ (
    .offset_i      (offset),
    .avg_i         (avg),
    .target_i      (target_black_i),
    .integ_sel_i   (integ_sel),
    .next_offset_o (next_offset)
  );

  // A software write in the same cycle as an update takes priority
  wire loop_update = (state == BLCL_UPDATE) && loop_enable_i;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      offset <= '0;
    end else if (offset_wr_i) begin
      offset <= offset_wr_data_i;
    end else if (loop_update) begin
      offset <= next_offset;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  // Flags are taken from the next state so that they change on the same
  // edge as the state register instead of trailing it by one cycle
  wire next_window = (next_state == BLCL_WINDOW);
  wire next_run    = (next_state != BLCL_IDLE);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      black_calib_window_o <= 1'b0;
    end else begin
      black_calib_window_o <= next_window;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_running_o <= 1'b0;
    end else begin
      loop_running_o <= next_run;
    end
  end

  assign offset_dac_o = offset;
  assign line_count_o = line_cnt;

endmodule : blcl_loop

//--- blcl_loop_assertions.sv
// Port-level checks for the black level correction loop
`timescale 1ns/100ps
module blcl_loop_checker
  import blcl_pkg::*;
#(
  parameter int OFFSET_W = 10
)
(
  input wire logic                       sys_clk_i,
  input wire logic                       rst_n_i,
  input wire logic                       reg_wr_i,
  input wire logic [7:0]                 reg_addr_i,
  input wire logic [7:0]                 reg_wr_data_i,
  input wire logic                       loop_enable_i,
  input wire logic                       offset_wr_i,
  input wire logic signed [OFFSET_W-1:0] offset_wr_data_i,
  input wire logic                       start_of_scan_i,
  input wire logic                       sensor_shift_pulse_i,
  input wire logic                       input_clamp_pulse_i,
  input wire logic signed [OFFSET_W-1:0] offset_dac_o,
  input wire logic                       black_calib_window_o,
  input wire logic                       loop_running_o,
  input wire logic [5:0]                 line_count_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] ctrl;
  logic [7:0] pos;
  logic [8:0] run_cnt;
  logic [5:0] win_cnt;
  logic [5:0] lim;
  assign lim = (ctrl[7:6] == 2'h0) ? 6'h0F :
               (ctrl[7:6] == 2'h1) ? 6'h1F : 6'h3F;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow registers and cycle counters
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl    <= 8'h00;
      pos     <= 8'h00;
      run_cnt <= 9'h000;
      win_cnt <= 6'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == BLCL_ADDR_CTRL) begin
        ctrl <= reg_wr_data_i;
      end
      if (reg_wr_i && reg_addr_i == BLCL_ADDR_POS) begin
        pos <= reg_wr_data_i;
      end
      run_cnt <= loop_running_o ? run_cnt + 9'h001 : 9'h000;
      win_cnt <= black_calib_window_o ? win_cnt + 6'h01 : 6'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_manual_load: assert property (offset_wr_i |=>
    offset_dac_o == $past(offset_wr_data_i)) else $error("manual load lost");
  a_update_after_window: assert property (
    $changed(offset_dac_o) && !$past(offset_wr_i) |-> $past(loop_enable_i)
    && $past(black_calib_window_o, 2) && !$past(black_calib_window_o))
    else $error("offset changed outside an update");
  a_window_in_run: assert property (black_calib_window_o |->
    loop_running_o) else $error("window outside a running line");
  a_window_start: assert property ($rose(black_calib_window_o) |->
    run_cnt == {1'b0, pos} + 9'h001) else $error("window start misplaced");
  a_window_length: assert property (
    $fell(black_calib_window_o) && $past(loop_enable_i) |->
    win_cnt == 6'(6'h04 << ctrl[5:4])) else $error("wrong pixel count");
  a_update_ends_run: assert property ($fell(black_calib_window_o) |=>
    !loop_running_o) else $error("line did not finish");
  a_count_step: assert property (
    (ctrl[1:0] == 2'h1 && $fell(sensor_shift_pulse_i) ||
     ctrl[1:0] == 2'h2 && $fell(input_clamp_pulse_i)) && !start_of_scan_i
    && line_count_o != 6'h3F |=> line_count_o == $past(line_count_o) + 6'h01)
    else $error("line count did not step");
  a_scan_clears: assert property (start_of_scan_i |=>
    line_count_o == 6'h00) else $error("line count not cleared");
  a_line_limit: assert property (
    $rose(loop_running_o) && ctrl[7:6] != 2'h3 |-> line_count_o <= lim)
    else $error("line ran past its limit");
  a_no_reference: assert property (
    $past(ctrl[1:0]) == 2'h0 || $past(ctrl[1:0]) == 2'h3 |->
    !$rose(loop_running_o)) else $error("line ran with no reference");
endmodule : blcl_loop_checker

bind blcl_loop blcl_loop_checker #(.OFFSET_W(OFFSET_W)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i), .reg_wr_data_i(reg_wr_data_i),
  .loop_enable_i(loop_enable_i), .offset_wr_i(offset_wr_i),
  .offset_wr_data_i(offset_wr_data_i), .start_of_scan_i(start_of_scan_i),
  .sensor_shift_pulse_i(sensor_shift_pulse_i),
  .input_clamp_pulse_i(input_clamp_pulse_i), .offset_dac_o(offset_dac_o),
  .black_calib_window_o(black_calib_window_o),
  .loop_running_o(loop_running_o), .line_count_o(line_count_o));

//--- blcl_adc_model.sv
// ADC and offset DAC as seen from one correction channel
`timescale 1ns/100ps
module blcl_adc_model
  import blcl_pkg::*;
#(
  parameter int BASE = 600
)
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  sensor_shift_pulse_i,
  input  wire logic                  dark_i,
  input  wire logic signed [9:0]     offset_dac_i,
  output logic      [BLCL_ADC_W-1:0] adc_code_o
);
  logic [7:0] pix;
  // Each pixel after the shift pulse reads one step higher, so a wrong
  // window position or pixel count shows up in the average
  always_ff @(posedge sys_clk_i) begin
    pix <= sensor_shift_pulse_i ? 8'h00 : pix + 8'h01;
  end
  // One offset step moves the code by one compare step; dark is a stuck input
  assign adc_code_o = dark_i ? 16'h0000 :
    16'((BASE + int'(offset_dac_i) + int'(pix)) * 16);
endmodule : blcl_adc_model

//--- blcl_loop_bench.sv
// Self-checking bench for the black level correction loop
`timescale 1ns/100ps
module blcl_loop_bench;
  import blcl_pkg::*;
  localparam int BASE = 600;
  logic              clk, rst_n, reg_wr, en, off_wr, sos, shift, clamp, dark;
  logic              win, run;
  logic [7:0]        addr, wdata, rdata;
  logic [9:0]        tgt;
  logic signed [9:0] wr_off, off, exp_off;
  logic [15:0]       adc;
  logic [5:0]        cnt;
  int                failures, check_count;

  blcl_loop i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(reg_wr),
    .reg_addr_i(addr), .reg_wr_data_i(wdata), .reg_rd_data_o(rdata),
    .loop_enable_i(en), .target_black_i(tgt), .offset_wr_i(off_wr),
    .offset_wr_data_i(wr_off), .start_of_scan_i(sos),
    .sensor_shift_pulse_i(shift), .input_clamp_pulse_i(clamp),
    .adc_code_i(adc), .offset_dac_o(off), .black_calib_window_o(win),
    .loop_running_o(run), .line_count_o(cnt));
  blcl_adc_model #(.BASE(BASE)) i_adc (.sys_clk_i(clk),
    .sensor_shift_pulse_i(shift), .dark_i(dark), .offset_dac_i(off),
    .adc_code_o(adc));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [15:0] exp, got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    reg_wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk("register", {8'h00, exp}, {8'h00, rdata});
  endtask : rd

  // One line: clamp, pulsed only when it is the reference (d > 0), falls
  // three pixels after shift, so no window ever meets a live clamp pulse
  task automatic line(input int n, d, ps, ds, input bit act);
    int avg;
    int v;
    @(negedge clk);
    shift = 1'b1;
    clamp = (d > 0);
    repeat (3) @(negedge clk);
    shift = 1'b0;
    repeat (3) @(negedge clk);
    clamp = 1'b0;
    repeat (60) @(negedge clk);
    avg = dark ? 0 : BASE + exp_off + n + 2 + d + ((4 << ps) - 1) / 2;
    v = exp_off + ((int'(tgt) - avg) >>> (3 + ds));
    v = v > 511 ? 511 : (v < -512 ? -512 : v);
    exp_off = act ? 10'(v) : exp_off;
    chk("offset", 16'(exp_off), 16'(off));
  endtask : line

  task automatic scan(input bit w, input logic signed [9:0] v);
    @(negedge clk);
    sos = 1'b1;
    off_wr = w;
    wr_off = v;
    @(negedge clk);
    sos = 1'b0;
    off_wr = 1'b0;
  endtask : scan
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    wr(8'h08, 8'hA5);
    wr(8'h09, 8'h3C);
    wr(8'h0A, 8'hFF);
    rd(8'h08, 8'hA5);
    rd(8'h09, 8'h3C);
    rd(8'h0A, 8'h00);
    $display("done: registers");
  endtask : t_regs

  task automatic t_manual();
    wr(8'h08, 8'hC1);
    wr(8'h09, 8'h00);
    scan(1'b1, 10'sd100);
    exp_off = 10'sd100;
    chk("manual offset", 16'(exp_off), 16'(off));
    line(0, 0, 0, 0, 1'b0);
    chk("line count", 16'h0001, 16'(cnt));
    $display("done: manual offset");
  endtask : t_manual

  task automatic t_sweep();
    en = 1'b1;
    tgt = 10'd700;
    wr(8'h08, 8'hC0);
    line(0, 0, 0, 0, 1'b0);
    for (int r = 1; r < 3; r++) begin
      for (int i = 0; i < 4; i++) begin
        wr(8'h08, {2'h3, 2'(i), 2'(3 - i), 2'(r)});
        wr(8'h09, 8'(i));
        line(i, 3 * (r - 1), i, 3 - i, 1'b1);
      end
    end
    $display("done: reference, pixel and divisor sweep");
  endtask : t_sweep

  // The target jumps on the first line past the limit, which must be ignored
  task automatic t_limit();
    for (int s = 0; s < 3; s++) begin
      wr(8'h08, {2'(s), 4'h0, 2'h1});
      wr(8'h09, 8'h02);
      scan(1'b0, 10'sd0);
      for (int k = 0; k < (16 << s); k++) begin
        tgt = (k == (16 << s) - 1) ? 10'd1000 : 10'd700;
        line(2, 0, 0, 0, k < (16 << s) - 1);
      end
      chk("line count", 16'(s == 2 ? 63 : 16 << s), 16'(cnt));
    end
    $display("done: line limits");
  endtask : t_limit

  // Counter is saturated here, so every update proves the endless setting
  task automatic t_sat();
    wr(8'h08, 8'hC1);
    wr(8'h09, 8'h01);
    for (int k = 0; k < 30; k++) begin
      dark = k < 6;
      tgt = k < 6 ? 10'h3FF : 10'h000;
      line(1, 0, 0, 0, 1'b1);
    end
    dark = 1'b0;
    tgt = 10'h3FF;
    en = 1'b0;
    line(1, 0, 0, 0, 1'b0);
    $display("done: saturation");
  endtask : t_sat
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, en, off_wr, sos, shift, clamp, dark} = '0;
    addr = 8'h00;
    wdata = 8'h00;
    tgt = 10'h000;
    wr_off = 10'sd0;
    exp_off = 10'sd0;
    failures = 0;
    check_count = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_manual();
    t_sweep();
    t_limit();
    t_sat();
    summarize();
  end

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule : blcl_loop_bench
